//--- core/gpc_pin_ctrl.sv
`timescale 1ns/1ps
module gpc_pin_ctrl (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// pads
	input  wire logic [31:0] i_pad_in,
	output logic [31:0]      o_pad_out,
	output logic [31:0]      o_pad_oe,
	output logic [31:0]      o_pad_ie,
	output logic [31:0]      o_pad_pue,
	output logic [31:0]      o_pad_ds,
	// hardware functions
	input  wire logic [31:0] i_hwf0_out,
	input  wire logic [31:0] i_hwf0_oe,
	input  wire logic [31:0] i_hwf1_out,
	input  wire logic [31:0] i_hwf1_oe,
	output logic [31:0]      o_hwf_in,
	// interrupts
	output logic [31:0]      o_irq_pin,
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////
	logic [31:0] receive_enable;
	logic [31:0] drive_enable;
	logic [31:0] drive_value;
	logic [31:0] pullup_enable;
	logic [31:0] drive_strength;
	logic [31:0] rising_edge_irq_enable, rising_edge_irq_pending;
	logic [31:0] falling_edge_irq_enable, falling_edge_irq_pending;
	logic [31:0] high_level_irq_enable, high_level_irq_pending;
	logic [31:0] low_level_irq_enable, low_level_irq_pending;
	logic [31:0] hw_function_enable, hw_function_select;
	logic [31:0] output_invert;
	logic [31:0] bypass_active_high_irq_enable;
	logic [31:0] bypass_active_low_irq_enable;
	logic [31:0] irq_mask;

	logic [31:0] sync_meta, sync_lvl, sync_prev;

	logic        acc_bad, wr_go, rd_miss;
	logic [31:0] rdata;
	logic [31:0] hw_act;
	logic [31:0] next_out, next_oe;
	logic [31:0] next_pin_irq;
	logic [31:0] rise_ev, fall_ev;

	function automatic logic wr_hit(input logic [11:0] off);
		wr_hit = wr_go && (i_paddr == off);
	endfunction : wr_hit

	////////////////////////////////////////////////////////////////////////
	// apb: one wait state, pready pulses in the second access cycle
	assign wr_go = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
	assign acc_bad = (i_paddr[1:0] != 2'b00) || rd_miss
		|| (i_pwrite && i_pstrb != gpc_pkg::STRB_FULL);

	always_comb begin
		rd_miss = 1'b0;
		rdata   = gpc_pkg::RST_ZERO;
		if (i_paddr == gpc_pkg::OFF_PIN_LEVEL) begin
			rdata = i_pad_in & receive_enable;
		end else if (i_paddr == gpc_pkg::OFF_RX_EN) begin
			rdata = receive_enable;
		end else if (i_paddr == gpc_pkg::OFF_DRV_EN) begin
			rdata = drive_enable;
		end else if (i_paddr == gpc_pkg::OFF_DRV_VAL) begin
			rdata = drive_value;
		end else if (i_paddr == gpc_pkg::OFF_PULLUP) begin
			rdata = pullup_enable;
		end else if (i_paddr == gpc_pkg::OFF_DRV_STR) begin
			rdata = drive_strength;
		end else if (i_paddr == gpc_pkg::OFF_RISING_EDGE_IRQ_ENABLE) begin
			rdata = rising_edge_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING) begin
			rdata = rising_edge_irq_pending;
		end else if (i_paddr == gpc_pkg::OFF_FALLING_EDGE_IRQ_ENABLE) begin
			rdata = falling_edge_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_FALLING_EDGE_IRQ_PENDING) begin
			rdata = falling_edge_irq_pending;
		end else if (i_paddr == gpc_pkg::OFF_HIGH_LEVEL_IRQ_ENABLE) begin
			rdata = high_level_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_HIGH_LEVEL_IRQ_PENDING) begin
			rdata = high_level_irq_pending;
		end else if (i_paddr == gpc_pkg::OFF_LOW_LEVEL_IRQ_ENABLE) begin
			rdata = low_level_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_LOW_LEVEL_IRQ_PENDING) begin
			rdata = low_level_irq_pending;
		end else if (i_paddr == gpc_pkg::OFF_HWF_EN) begin
			rdata = hw_function_enable;
		end else if (i_paddr == gpc_pkg::OFF_HWF_SEL) begin
			rdata = hw_function_select;
		end else if (i_paddr == gpc_pkg::OFF_INVERT) begin
			rdata = output_invert;
		end else if (i_paddr == gpc_pkg::OFF_BYP_HI_IE) begin
			rdata = bypass_active_high_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_BYP_LO_IE) begin
			rdata = bypass_active_low_irq_enable;
		end else if (i_paddr == gpc_pkg::OFF_IRQ_MASK) begin
			rdata = irq_mask;
		end else begin
			rd_miss = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_pready  <= 1'b0;
			o_prdata  <= gpc_pkg::RST_ZERO;
			o_pslverr <= 1'b0;
		end else if (i_psel && i_penable && !o_pready) begin
			o_pready  <= 1'b1;
			o_pslverr <= acc_bad;
			o_prdata  <= (acc_bad || i_pwrite) ? gpc_pkg::RST_ZERO : rdata;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive, drive and pull-up enable registers fall even without a running clock; o_pad_ie, o_pad_oe and o_pad_pue only clear on a clock edge
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			receive_enable <= gpc_pkg::RST_ZERO;
			drive_enable   <= gpc_pkg::RST_ZERO;
			pullup_enable  <= gpc_pkg::RST_ZERO;
		end else begin
			if (wr_hit(gpc_pkg::OFF_RX_EN))
				receive_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_DRV_EN))
				drive_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_PULLUP))
				pullup_enable <= i_pwdata;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			drive_value                   <= gpc_pkg::RST_ZERO;
			drive_strength                <= gpc_pkg::RST_ZERO;
			rising_edge_irq_enable        <= gpc_pkg::RST_ZERO;
			falling_edge_irq_enable       <= gpc_pkg::RST_ZERO;
			high_level_irq_enable         <= gpc_pkg::RST_ZERO;
			low_level_irq_enable          <= gpc_pkg::RST_ZERO;
			hw_function_enable            <= gpc_pkg::RST_ZERO;
			hw_function_select            <= gpc_pkg::RST_ZERO;
			output_invert                 <= gpc_pkg::RST_ZERO;
			bypass_active_high_irq_enable <= gpc_pkg::RST_ZERO;
			bypass_active_low_irq_enable  <= gpc_pkg::RST_ZERO;
			irq_mask                      <= gpc_pkg::RST_ZERO;
		end else begin
			if (wr_hit(gpc_pkg::OFF_DRV_VAL))
				drive_value <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_DRV_STR))
				drive_strength <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_RISING_EDGE_IRQ_ENABLE))
				rising_edge_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_FALLING_EDGE_IRQ_ENABLE))
				falling_edge_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_HIGH_LEVEL_IRQ_ENABLE))
				high_level_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_LOW_LEVEL_IRQ_ENABLE))
				low_level_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_HWF_EN))
				hw_function_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_HWF_SEL))
				hw_function_select <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_INVERT))
				output_invert <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_BYP_HI_IE))
				bypass_active_high_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_BYP_LO_IE))
				bypass_active_low_irq_enable <= i_pwdata;
			if (wr_hit(gpc_pkg::OFF_IRQ_MASK))
				irq_mask <= i_pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pad control; hardware owns only value and direction
	assign hw_act = hw_function_enable
		& ((~hw_function_select & gpc_pkg::HWF0_EXISTS)
		| (hw_function_select & gpc_pkg::HWF1_EXISTS));
	assign next_out = ((hw_act & ((~hw_function_select & i_hwf0_out)
		| (hw_function_select & i_hwf1_out)))
		| (~hw_act & drive_value)) ^ output_invert;
	assign next_oe = (hw_act & ((~hw_function_select & i_hwf0_oe)
		| (hw_function_select & i_hwf1_oe)))
		| (~hw_act & drive_enable);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_pad_out <= gpc_pkg::RST_ZERO;
			o_pad_oe  <= gpc_pkg::RST_ZERO;
			o_pad_ie  <= gpc_pkg::RST_ZERO;
			o_pad_pue <= gpc_pkg::RST_ZERO;
			o_pad_ds  <= gpc_pkg::RST_ZERO;
			o_hwf_in  <= gpc_pkg::RST_ZERO;
		end else begin
			o_pad_out <= next_out;
			o_pad_oe  <= next_oe;
			o_pad_ie  <= receive_enable;
			o_pad_pue <= pullup_enable & ~next_oe;
			o_pad_ds  <= drive_strength & next_oe;
			o_hwf_in  <= i_pad_in & receive_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser, third flop only for edge history
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sync_meta <= gpc_pkg::RST_ZERO;
			sync_lvl  <= gpc_pkg::RST_ZERO;
			sync_prev <= gpc_pkg::RST_ZERO;
		end else begin
			sync_meta <= i_pad_in;
			sync_lvl  <= sync_meta;
			sync_prev <= sync_lvl;
		end
	end

	assign rise_ev = sync_lvl & ~sync_prev & rising_edge_irq_enable;
	assign fall_ev = ~sync_lvl & sync_prev & falling_edge_irq_enable;

	// set wins over a same-cycle write-one clear
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rising_edge_irq_pending  <= gpc_pkg::RST_ZERO;
			falling_edge_irq_pending <= gpc_pkg::RST_ZERO;
			high_level_irq_pending   <= gpc_pkg::RST_ZERO;
			low_level_irq_pending    <= gpc_pkg::RST_ZERO;
		end else begin
			rising_edge_irq_pending <= (rising_edge_irq_pending
				& ~({32{wr_hit(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING)}} & i_pwdata))
				| rise_ev;
			falling_edge_irq_pending <= (falling_edge_irq_pending
				& ~({32{wr_hit(gpc_pkg::OFF_FALLING_EDGE_IRQ_PENDING)}} & i_pwdata))
				| fall_ev;
			high_level_irq_pending <= (high_level_irq_pending
				& ~({32{wr_hit(gpc_pkg::OFF_HIGH_LEVEL_IRQ_PENDING)}} & i_pwdata))
				| sync_lvl;
			low_level_irq_pending <= (low_level_irq_pending
				& ~({32{wr_hit(gpc_pkg::OFF_LOW_LEVEL_IRQ_PENDING)}} & i_pwdata))
				| ~sync_lvl;
		end
	end

	assign next_pin_irq = rising_edge_irq_pending
		| falling_edge_irq_pending
		| (high_level_irq_pending & high_level_irq_enable)
		| (low_level_irq_pending & low_level_irq_enable)
		| (bypass_active_high_irq_enable & sync_lvl)
		| (bypass_active_low_irq_enable & ~sync_lvl);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq_pin <= gpc_pkg::RST_ZERO;
			o_irq     <= 1'b0;
		end else begin
			o_irq_pin <= next_pin_irq;
			o_irq     <= |(next_pin_irq & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_rst_enables;
		@(posedge i_ref_clk) disable iff (1'b0)
		i_rst |=> (receive_enable == 32'h0) && (drive_enable == 32'h0)
			&& (pullup_enable == 32'h0);
	endproperty
	a_rst_enables: assert property (p_rst_enables)
		else $error("enables not cleared by reset");
	property p_drv_val_wr;
		wr_hit(gpc_pkg::OFF_DRV_VAL) |=> drive_value == $past(i_pwdata);
	endproperty
	a_drv_val_wr: assert property (p_drv_val_wr)
		else $error("output value write lost");
	property p_pin_read;
		(i_psel && i_penable && !o_pready && !i_pwrite
			&& i_paddr == gpc_pkg::OFF_PIN_LEVEL)
		|=> o_pready && o_prdata == $past(i_pad_in & receive_enable);
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("pin level read wrong");
	property p_rise_set;
		(rise_ev != 32'h0) |=>
			((rising_edge_irq_pending & $past(rise_ev)) == $past(rise_ev));
	endproperty
	a_rise_set: assert property (p_rise_set)
		else $error("rising edge not recorded");
	// a level about to leave the second flop must be pending two edges on
	property p_fall_late;
		(~sync_meta & sync_lvl & falling_edge_irq_enable) != 32'h0
		|=> ##1 ((falling_edge_irq_pending
			& $past(~sync_meta & sync_lvl & falling_edge_irq_enable, 2))
			== $past(~sync_meta & sync_lvl & falling_edge_irq_enable, 2));
	endproperty
	a_fall_late: assert property (p_fall_late)
		else $error("falling edge not seen after sync");
	property p_pend_hold;
		!wr_hit(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING) |=>
			(($past(rising_edge_irq_pending) & ~rising_edge_irq_pending)
			== 32'h0);
	endproperty
	a_pend_hold: assert property (p_pend_hold)
		else $error("pending bit dropped without clear");
	property p_edge_irq;
		(rising_edge_irq_pending | falling_edge_irq_pending) != 32'h0
		|=> ((o_irq_pin & $past(rising_edge_irq_pending
			| falling_edge_irq_pending))
			== $past(rising_edge_irq_pending | falling_edge_irq_pending));
	endproperty
	a_edge_irq: assert property (p_edge_irq)
		else $error("pending edge did not raise interrupt");
	property p_sw_out;
		hw_function_enable == 32'h0
		|=> o_pad_out == $past(drive_value ^ output_invert)
			&& o_pad_oe == $past(drive_enable);
	endproperty
	a_sw_out: assert property (p_sw_out)
		else $error("software pad output wrong");
	property p_missing_fn;
		hw_function_enable[14] |=>
			o_pad_out[14] == $past(drive_value[14] ^ output_invert[14]);
	endproperty
	a_missing_fn: assert property (p_missing_fn)
		else $error("missing function took the pin");
	property p_bypass;
		bypass_active_low_irq_enable[0] && !sync_lvl[0] |=> o_irq_pin[0];
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("pass-through level not forwarded");
endmodule : gpc_pin_ctrl

//--- core/gpc_pkg.sv
package gpc_pkg;

	localparam int NPIN   = 32;
	localparam int ADDR_W = 12;
	localparam int SYNC_N = 2;

	// register byte offsets
	localparam logic [11:0] OFF_PIN_LEVEL  = 12'h000;
	localparam logic [11:0] OFF_RX_EN      = 12'h004;
	localparam logic [11:0] OFF_DRV_EN     = 12'h008;
	localparam logic [11:0] OFF_DRV_VAL    = 12'h00c;
	localparam logic [11:0] OFF_PULLUP     = 12'h010;
	localparam logic [11:0] OFF_DRV_STR    = 12'h014;
	localparam logic [11:0] OFF_RISING_EDGE_IRQ_ENABLE    = 12'h018;
	localparam logic [11:0] OFF_RISING_EDGE_IRQ_PENDING    = 12'h01c;
	localparam logic [11:0] OFF_FALLING_EDGE_IRQ_ENABLE    = 12'h020;
	localparam logic [11:0] OFF_FALLING_EDGE_IRQ_PENDING    = 12'h024;
	localparam logic [11:0] OFF_HIGH_LEVEL_IRQ_ENABLE    = 12'h028;
	localparam logic [11:0] OFF_HIGH_LEVEL_IRQ_PENDING    = 12'h02c;
	localparam logic [11:0] OFF_LOW_LEVEL_IRQ_ENABLE     = 12'h030;
	localparam logic [11:0] OFF_LOW_LEVEL_IRQ_PENDING     = 12'h034;
	localparam logic [11:0] OFF_HWF_EN     = 12'h038;
	localparam logic [11:0] OFF_HWF_SEL    = 12'h03c;
	localparam logic [11:0] OFF_INVERT     = 12'h040;
	localparam logic [11:0] OFF_BYP_HI_IE  = 12'h044;
	localparam logic [11:0] OFF_BYP_LO_IE  = 12'h048;
	localparam logic [11:0] OFF_IRQ_MASK   = 12'h04c;

	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [3:0]  STRB_FULL  = 4'hf;

	// pins where function 0 / function 1 actually exist
	localparam logic [31:0] HWF0_EXISTS = 32'hfc87_37fc;
	localparam logic [31:0] HWF1_EXISTS = 32'h0078_3c0f;

endpackage : gpc_pkg

//--- sim/gpc_pad_model.sv
`timescale 1ns/1ps
module gpc_pad_model (
	// clock
	input  wire logic        i_ref_clk,
	// controller side
	input  wire logic [31:0] i_pad_out,
	input  wire logic [31:0] i_pad_oe,
	input  wire logic [31:0] i_pad_pue,
	// external drivers
	input  wire logic [31:0] i_ext_val,
	input  wire logic [31:0] i_ext_en,
	output logic [31:0]      o_pad_level
);
	// floating pads wander each cycle so no value settles by luck
	logic [31:0] drift = 32'h0000_0000;

	always_ff @(posedge i_ref_clk) begin
		drift <= ~drift;
	end

	always_comb begin
		o_pad_level = (i_pad_oe & i_pad_out)
			| (~i_pad_oe & i_ext_en & i_ext_val)
			| (~i_pad_oe & ~i_ext_en & i_pad_pue)
			| (~i_pad_oe & ~i_ext_en & ~i_pad_pue & drift);
	end
endmodule : gpc_pad_model

//--- sim/gpc_pin_ctrl_bench.sv
`timescale 1ns/1ps
module gpc_pin_ctrl_bench;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, pad_in, pad_out, oe, ie, pue, ds;
	logic [31:0] h0o, h0e, h1o, h1e, hwf_in, irq_pin, ext_val, ext_en;
	logic [31:0] v, m, o, dv, x, p, s, sel, use_f, hout, hoe;
	logic [31:0] exp_d[$];
	logic        exp_e[$];
	int          err_count, comparisons;

	gpc_pin_ctrl dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_pad_in(pad_in),
		.o_pad_out(pad_out), .o_pad_oe(oe), .o_pad_ie(ie), .o_pad_pue(pue),
		.o_pad_ds(ds), .i_hwf0_out(h0o), .i_hwf0_oe(h0e), .i_hwf1_out(h1o),
		.i_hwf1_oe(h1e), .o_hwf_in(hwf_in), .o_irq_pin(irq_pin), .o_irq(irq));

	gpc_pad_model pads (.i_ref_clk(clk), .i_pad_out(pad_out), .i_pad_oe(oe),
		.i_pad_pue(pue), .i_ext_val(ext_val), .i_ext_en(ext_en),
		.o_pad_level(pad_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task check(input string n, input logic [31:0] seen, input logic [31:0] e);
		comparisons++;
		if (seen !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, seen);
		end
	endtask : check

	task end_of_test;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	// one idle cycle after each transfer keeps psel single-driven per step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [31:0] er, input logic ee);
		exp_d.push_back(er);
		exp_e.push_back(ee);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle limit here: a slave that never answers meets the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf, 32'h0, 1'b0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'hf, e, 1'b0);
	endtask : rd

	task rs;
		rst <= 1'b1;
		wt(2);
		rst <= 1'b0;
		wt(2);
	endtask : rs

	task pads_chk;
		logic [31:0] eo;
		eo = (use_f & hoe) | (~use_f & o);
		check("pad_oe", oe, eo);
		check("pad_out", pad_out, ((use_f & hout) | (~use_f & dv)) ^ x);
		check("pad_pue", pue, p & ~eo);
		check("pad_ds", ds, s & eo);
		check("pad_ie", ie, m);
		check("hwf_in", hwf_in, pad_in & m);
	endtask : pads_chk

	always @(posedge clk) begin
		if (pready === 1'b1 && exp_d.size() > 0) begin
			check("prdata", prdata, exp_d.pop_front());
			check("pslverr", {31'h0, pslverr}, {31'h0, exp_e.pop_front()});
		end
	end

	initial begin
		wt(20000);
		err_count++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b100, 45'h0, 4'hf};
		{ext_val, ext_en, h0o, h0e, h1o, h1e} = {32'h0, 32'hffff_ffff, 128'h0};
		{err_count, comparisons, use_f, hout, hoe} = '0;
		v = $urandom(72);
		rs();
		// every plain register holds what was written
		for (int i = 1; i < 20; i++) begin
			v = $urandom;
			if (!(i inside {7, 9, 11, 13})) begin
				wr(12'(i * 4), v);
				rd(12'(i * 4), v);
			end
		end
		wr(gpc_pkg::OFF_DRV_VAL, 32'ha5a5_a5a5);
		apb(1'b1, gpc_pkg::OFF_DRV_VAL, 32'h0, 4'h3, 32'h0, 1'b1);
		apb(1'b0, 12'h050, 32'h0, 4'hf, 32'h0, 1'b1);
		apb(1'b0, 12'h006, 32'h0, 4'hf, 32'h0, 1'b1);
		apb(1'b1, gpc_pkg::OFF_PIN_LEVEL, 32'hffff_ffff, 4'hf, 32'h0, 1'b0);
		rd(gpc_pkg::OFF_DRV_VAL, 32'ha5a5_a5a5);
		// mid-run reset; level pendings may refill at once, so skipped
		rs();
		for (int i = 0; i < 20; i++) begin
			if (!(i inside {11, 13})) rd(12'(i * 4), 32'h0);
		end
		check("pad_ie", ie | oe | pue, 32'h0);
		// software pad control
		v = $urandom;
		ext_val <= v;
		{m, o, dv, x, p, s} = {$urandom, $urandom, $urandom, $urandom,
			$urandom, $urandom};
		wr(gpc_pkg::OFF_RX_EN, m);
		rd(gpc_pkg::OFF_PIN_LEVEL, v & m);
		wr(gpc_pkg::OFF_DRV_EN, o);
		wr(gpc_pkg::OFF_DRV_VAL, dv);
		wr(gpc_pkg::OFF_INVERT, x);
		wr(gpc_pkg::OFF_PULLUP, p);
		wr(gpc_pkg::OFF_DRV_STR, s);
		wt(3);
		pads_chk();
		// hardware functions, missing ones fall back to software
		{h0o, h0e, h1o, h1e} <= {$urandom, $urandom, $urandom, $urandom};
		v = $urandom;
		sel = $urandom;
		wr(gpc_pkg::OFF_HWF_EN, v);
		wr(gpc_pkg::OFF_HWF_SEL, sel);
		use_f = v & ((sel & gpc_pkg::HWF1_EXISTS)
			| (~sel & gpc_pkg::HWF0_EXISTS));
		hout = (sel & h1o) | (~sel & h0o);
		hoe = (sel & h1e) | (~sel & h0e);
		wt(3);
		pads_chk();
		// interrupts
		ext_val <= 32'h0;
		rs();
		wr(gpc_pkg::OFF_IRQ_MASK, 32'hffff_ffff);
		wr(gpc_pkg::OFF_RISING_EDGE_IRQ_ENABLE, 32'h8);
		wr(gpc_pkg::OFF_FALLING_EDGE_IRQ_ENABLE, 32'h8);
		ext_val <= 32'h8;
		wt(8);
		check("irq_pin", irq_pin, 32'h8);
		check("irq", {31'h0, irq}, 32'h1);
		rd(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING, 32'h8);
		rd(gpc_pkg::OFF_HIGH_LEVEL_IRQ_PENDING, 32'h8);
		rd(gpc_pkg::OFF_LOW_LEVEL_IRQ_PENDING, 32'hffff_ffff);
		wr(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING, 32'h0);
		rd(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING, 32'h8);
		wr(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING, 32'h8);
		rd(gpc_pkg::OFF_RISING_EDGE_IRQ_PENDING, 32'h0);
		check("irq_pin", irq_pin, 32'h0);
		ext_val <= 32'h0;
		wt(8);
		rd(gpc_pkg::OFF_FALLING_EDGE_IRQ_PENDING, 32'h8);
		wr(gpc_pkg::OFF_IRQ_MASK, 32'h0);
		wt(2);
		check("irq_pin", irq_pin, 32'h8);
		check("irq", {31'h0, irq}, 32'h0);
		wr(gpc_pkg::OFF_FALLING_EDGE_IRQ_PENDING, 32'h8);
		wr(gpc_pkg::OFF_HIGH_LEVEL_IRQ_ENABLE, 32'h80);
		ext_val <= 32'h80;
		wt(8);
		check("irq_pin", irq_pin, 32'h80);
		wr(gpc_pkg::OFF_HIGH_LEVEL_IRQ_ENABLE, 32'h0);
		wr(gpc_pkg::OFF_BYP_HI_IE, 32'h1000);
		ext_val <= 32'h1080;
		wt(6);
		check("irq_pin", irq_pin, 32'h1000);
		ext_val <= 32'h80;
		wt(6);
		check("irq_pin", irq_pin, 32'h0);
		// pin 2 has sat low since the reset, so its low pending is set
		wr(gpc_pkg::OFF_LOW_LEVEL_IRQ_ENABLE, 32'h4);
		wt(2);
		check("irq_pin", irq_pin, 32'h4);
		wr(gpc_pkg::OFF_BYP_LO_IE, 32'h2001);
		wt(4);
		check("irq_pin", irq_pin, 32'h2005);
		end_of_test();
	end
endmodule : gpc_pin_ctrl_bench
